// >>> adcseq_regs.vh
// Constants for the four-sequencer converter sampling control.
// Assumes a single 20 MHz clock and synchronous active-high reset.
// Function
// - Four sequencers 0..3 with eight, four, four and one steps.
// - Each sequencer may start on a processor-issued trigger.
// - Trigger choices: three comparators, external pin, timer, three PWM.
// - Continuous trigger keeps capturing while no higher priority is active.
// - Priority 0..3 per sequencer; value 0 served first, 3 last.
// - A disabled sequencer ignores triggers; a run under way stops after storing its current step.
// - An enabled sequencer runs its steps when its trigger is detected.
// - Each sequencer shows how many results its FIFO holds.
// - Overflow flag sets when a trigger arrives with unread results.
// - Overflow stays set until cleared; new overflow seen only after clear.
// - Underflow flag sets when software reads an empty result FIFO.
// - Underflow stays set until cleared; new underflow seen after clear.
// - Step holds channel 0..7, differential bit, temperature select.
// - Sequencer stops after a step marked last.
// - Step interrupt bit raises sequencer interrupt status on completion.
// - Steps run ascending; indices 0..7, 0..3, 0..3 and 0.
// - Raw and masked interrupt status reported per sequencer.
// - Clearing a sequencer's interrupt status drops its request.
`ifndef ADCSEQ_REGS_VH
`define ADCSEQ_REGS_VH

// ============================================================
// Trigger select codes
`define ADCSEQ_TRIG_PROC 4'h0
`define ADCSEQ_TRIG_CMP1 4'h1
`define ADCSEQ_TRIG_CMP2 4'h2
`define ADCSEQ_TRIG_CMP3 4'h3
`define ADCSEQ_TRIG_EXT 4'h4
`define ADCSEQ_TRIG_TMR 4'h5
`define ADCSEQ_TRIG_PWM1 4'h6
`define ADCSEQ_TRIG_PWM2 4'h7
`define ADCSEQ_TRIG_PWM3 4'h8
`define ADCSEQ_TRIG_ALWAYS 4'hF

// ============================================================
// Step word fields
`define ADCSEQ_STEP_CH_LSB 0
`define ADCSEQ_STEP_DIFF 3
`define ADCSEQ_STEP_TEMP 4
`define ADCSEQ_STEP_LAST 5
`define ADCSEQ_STEP_IE 6
`define ADCSEQ_STEP_RST 7'h00

// ============================================================
// Step storage layout and last valid index per sequencer
`define ADCSEQ_BASE0 5'h00
`define ADCSEQ_BASE1 5'h08
`define ADCSEQ_BASE2 5'h0C
`define ADCSEQ_BASE3 5'h10
`define ADCSEQ_MAX0 3'h7
`define ADCSEQ_MAX1 3'h3
`define ADCSEQ_MAX2 3'h3
`define ADCSEQ_MAX3 3'h0
`define ADCSEQ_NSTEPS 17

// ============================================================
// Result path
`define ADCSEQ_RES_W 12
`define ADCSEQ_FIFO_DEPTH 16
`define ADCSEQ_FIFO_AW 4

// ============================================================
// Sequencer states
`define ADCSEQ_S_IDLE 2'h0
`define ADCSEQ_S_LOAD 2'h1
`define ADCSEQ_S_WAIT 2'h2
`define ADCSEQ_S_PUSH 2'h3

`endif

// >>> adcseq_fifo.v
// Result FIFO with valid/ready on both sides and registered read data.
// Assumes one clock; read data appear the cycle after a pop.
`timescale 1ns/100ps
module adcseq_fifo #(
   parameter WIDTH = 12,
   parameter DEPTH = 16,
   parameter AW = 4
) (
   input wire clk_i,
   input wire rst_i,
   input wire in_valid_i,
   output wire in_ready_o,
   input wire [WIDTH-1:0] in_data_i,
   output wire out_valid_o,
   input wire out_ready_i,
   output wire [WIDTH-1:0] out_data_o,
   output wire [AW:0] count_o
);
   localparam [AW:0] FULL = DEPTH;
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr_q;
   reg [AW-1:0] rd_ptr_q;
   reg [AW:0] count_q;
   reg [WIDTH-1:0] out_data_q;
   wire push;
   wire pop;

   // ============================================================
   // Flags; full is exact so the writer really stalls
   assign in_ready_o = (count_q != FULL);
   assign out_valid_o = (count_q != {(AW+1){1'b0}});
   assign push = in_valid_i & in_ready_o;
   assign pop = out_ready_i & out_valid_o;
   assign count_o = count_q;
   assign out_data_o = out_data_q;

   // Storage is not reset; only pointers carry meaning
   always @(posedge clk_i)
   begin
      if (push)
         mem[wr_ptr_q] <= in_data_i;
   end

   // Pointers, occupancy and registered read word
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wr_ptr_q <= {AW{1'b0}};
         rd_ptr_q <= {AW{1'b0}};
         count_q <= {(AW+1){1'b0}};
         out_data_q <= {WIDTH{1'b0}};
      end
      else
      begin
         if (push)
            wr_ptr_q <= wr_ptr_q + 1'b1;
         if (pop)
         begin
            rd_ptr_q <= rd_ptr_q + 1'b1;
            out_data_q <= mem[rd_ptr_q];
         end
         if (push && !pop)
            count_q <= count_q + 1'b1;
         else if (pop && !push)
            count_q <= count_q - 1'b1;
      end
   end
endmodule // adcseq_fifo

// >>> adcseq_top.v
// Four-sequencer sampling control: triggers, arbitration, step
// execution, result FIFOs, error flags and interrupt status.
// Assumes all inputs synchronous to clk_i and a converter core that
// answers each conv_start_o pulse with one conv_done_i pulse.
`timescale 1ns/100ps
`include "adcseq_regs.vh"
module adcseq_top (
   input wire clk_i,
   input wire rst_i,
   input wire [3:0] seq_enable_i,
   input wire [15:0] seq_trigger_select_i,
   input wire [7:0] seq_priority_i,
   input wire [3:0] proc_trig_i,
   input wire trig_comparator_first_i,
   input wire trig_comparator_second_i,
   input wire trig_comparator_third_i,
   input wire trig_external_i,
   input wire trig_timer_i,
   input wire trig_pwm_gen_first_i,
   input wire trig_pwm_gen_second_i,
   input wire trig_pwm_gen_third_i,
   input wire cfg_we_i,
   input wire [1:0] cfg_seq_i,
   input wire [2:0] seq_step_index_i,
   input wire [6:0] cfg_step_i,
   input wire rd_i,
   input wire [1:0] rd_seq_i,
   output wire [`ADCSEQ_RES_W-1:0] rd_data_o,
   output wire rd_valid_o,
   output wire [19:0] seq_fifo_count_o,
   input wire [3:0] seq_ovf_clr_i,
   input wire [3:0] seq_unf_clr_i,
   output wire [3:0] seq_overflow_o,
   output wire [3:0] seq_underflow_o,
   input wire [3:0] irq_mask_i,
   input wire [3:0] irq_clr_i,
   output wire [3:0] irq_raw_o,
   output wire [3:0] irq_masked_o,
   output wire conv_start_o,
   output wire [2:0] conv_channel_o,
   output wire conv_diff_o,
   output wire conv_temp_o,
   input wire conv_done_i,
   input wire [`ADCSEQ_RES_W-1:0] conv_data_i,
   output wire busy_o,
   output wire [1:0] active_seq_o
);
   reg [6:0] step_mem [0:`ADCSEQ_NSTEPS-1];
   reg [7:0] trig_prev_q;
   reg [3:0] pend_q;
   reg [3:0] ovf_q;
   reg [3:0] unf_q;
   reg [3:0] irq_q;
   reg [1:0] state_q;
   reg [1:0] cur_seq_q;
   reg [2:0] step_q;
   reg [6:0] step_word_q;
   reg [`ADCSEQ_RES_W-1:0] res_q;
   reg conv_start_q;
   reg [2:0] conv_channel_q;
   reg conv_diff_q;
   reg conv_temp_q;
   reg rd_pend_q;
   reg [1:0] rd_sel_q;
   reg [`ADCSEQ_RES_W-1:0] rd_data_q;
   reg rd_valid_q;
   reg win_found;
   reg [1:0] win_seq;
   wire [7:0] trig_now;
   wire [7:0] trig_evt;
   wire [3:0] hit;
   wire [3:0] start_oh;
   wire [3:0] fifo_in_ready;
   wire [3:0] fifo_out_valid;
   wire [3:0] fifo_pop;
   wire [3:0] fifo_push;
   wire [4*`ADCSEQ_RES_W-1:0] fifo_dout;
   wire [4:0] cur_idx;
   wire [4:0] cfg_idx;
   wire cfg_ok;
   wire start;
   wire push_done;
   wire seq_end;
   integer p;
   integer s;
   integer k;

   // ============================================================
   // Helper functions
   // Base of each sequencer's slice of the step storage
   function [4:0] step_base;
      input [1:0] sq;
      begin
         case (sq)
            2'h0: step_base = `ADCSEQ_BASE0;
            2'h1: step_base = `ADCSEQ_BASE1;
            2'h2: step_base = `ADCSEQ_BASE2;
            default: step_base = `ADCSEQ_BASE3;
         endcase
      end
   endfunction

   // Highest valid step index per sequencer
   function [2:0] step_max;
      input [1:0] sq;
      begin
         case (sq)
            2'h0: step_max = `ADCSEQ_MAX0;
            2'h1: step_max = `ADCSEQ_MAX1;
            2'h2: step_max = `ADCSEQ_MAX2;
            default: step_max = `ADCSEQ_MAX3;
         endcase
      end
   endfunction

   // Selected trigger source for one sequencer
   function trig_hit;
      input [3:0] sel;
      input proc;
      input [7:0] ev;
      begin
         case (sel)
            `ADCSEQ_TRIG_PROC: trig_hit = proc;
            `ADCSEQ_TRIG_CMP1: trig_hit = ev[0];
            `ADCSEQ_TRIG_CMP2: trig_hit = ev[1];
            `ADCSEQ_TRIG_CMP3: trig_hit = ev[2];
            `ADCSEQ_TRIG_EXT: trig_hit = ev[3];
            `ADCSEQ_TRIG_TMR: trig_hit = ev[4];
            `ADCSEQ_TRIG_PWM1: trig_hit = ev[5];
            `ADCSEQ_TRIG_PWM2: trig_hit = ev[6];
            `ADCSEQ_TRIG_PWM3: trig_hit = ev[7];
            `ADCSEQ_TRIG_ALWAYS: trig_hit = 1'b1;
            default: trig_hit = 1'b0;
         endcase
      end
   endfunction

   // ============================================================
   // Trigger detection
   // Hardware sources count on their rising edge so a held level
   // does not refire every cycle
   assign trig_now = {trig_pwm_gen_third_i, trig_pwm_gen_second_i,
      trig_pwm_gen_first_i, trig_timer_i, trig_external_i,
      trig_comparator_third_i, trig_comparator_second_i,
      trig_comparator_first_i};
   assign trig_evt = trig_now & ~trig_prev_q;

   always @(posedge clk_i)
   begin
      if (rst_i)
         trig_prev_q <= 8'h00;
      else
         trig_prev_q <= trig_now;
   end

   // ============================================================
   // Step configuration storage
   // Writes beyond a sequencer's last index are dropped
   assign cfg_idx = step_base(cfg_seq_i) + {2'b00, seq_step_index_i};
   assign cfg_ok = (seq_step_index_i <= step_max(cfg_seq_i));

   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         for (k = 0; k < `ADCSEQ_NSTEPS; k = k + 1)
            step_mem[k] <= `ADCSEQ_STEP_RST;
      end
      else if (cfg_we_i && cfg_ok)
         step_mem[cfg_idx] <= cfg_step_i;
   end

   // ============================================================
   // Per-sequencer triggers, FIFOs and sticky flags
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1)
      begin : gen_seq
         // Disabled sequencers see no trigger at all
         assign hit[g] = seq_enable_i[g] & trig_hit(
            seq_trigger_select_i[4*g+3:4*g], proc_trig_i[g], trig_evt);
         assign fifo_push[g] = push_done & (cur_seq_q == g);
         assign fifo_pop[g] = rd_i & (rd_seq_i == g);

         // Sixteen entries covers every sequencer's step count
         adcseq_fifo #(
            .WIDTH(`ADCSEQ_RES_W),
            .DEPTH(`ADCSEQ_FIFO_DEPTH),
            .AW(`ADCSEQ_FIFO_AW)
         ) u_fifo (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .in_valid_i(fifo_push[g]),
            .in_ready_o(fifo_in_ready[g]),
            .in_data_i(res_q),
            .out_valid_o(fifo_out_valid[g]),
            .out_ready_i(fifo_pop[g]),
            .out_data_o(fifo_dout[`ADCSEQ_RES_W*g +: `ADCSEQ_RES_W]),
            .count_o(seq_fifo_count_o[5*g+4:5*g])
         );

         // Sticky error and interrupt flags; a set beats a clear
         always @(posedge clk_i)
         begin
            if (rst_i)
            begin
               ovf_q[g] <= 1'b0;
               unf_q[g] <= 1'b0;
               irq_q[g] <= 1'b0;
            end
            else
            begin
               if (hit[g] && fifo_out_valid[g])
                  ovf_q[g] <= 1'b1;
               else if (seq_ovf_clr_i[g])
                  ovf_q[g] <= 1'b0;
               if (fifo_pop[g] && !fifo_out_valid[g])
                  unf_q[g] <= 1'b1;
               else if (seq_unf_clr_i[g])
                  unf_q[g] <= 1'b0;
               if (fifo_push[g] && step_word_q[`ADCSEQ_STEP_IE])
                  irq_q[g] <= 1'b1;
               else if (irq_clr_i[g])
                  irq_q[g] <= 1'b0;
            end
         end
      end
   endgenerate

   // ============================================================
   // Priority arbiter
   // Lower value wins; on a tie the higher-numbered sequencer
   // wins, as uniqueness is left to software
   always @*
   begin
      win_found = 1'b0;
      win_seq = 2'b00;
      for (p = 3; p >= 0; p = p - 1)
      begin
         for (s = 0; s < 4; s = s + 1)
         begin
            if (pend_q[s] && (seq_priority_i[2*s +: 2] == p[1:0]))
            begin
               win_found = 1'b1;
               win_seq = s[1:0];
            end
         end
      end
   end

   assign start = (state_q == `ADCSEQ_S_IDLE) & win_found;
   assign start_oh = start ? (4'h1 << win_seq) : 4'h0;

   // Pending triggers survive other sequencers' runs
   always @(posedge clk_i)
   begin
      if (rst_i)
         pend_q <= 4'h0;
      else
         pend_q <= ((pend_q & ~start_oh) | hit) & seq_enable_i;
   end

   // ============================================================
   // Step execution
   assign cur_idx = step_base(cur_seq_q) + {2'b00, step_q};
   assign push_done = (state_q == `ADCSEQ_S_PUSH) &
      fifo_in_ready[cur_seq_q];
   assign seq_end = step_word_q[`ADCSEQ_STEP_LAST] |
      (step_q == step_max(cur_seq_q)) | !seq_enable_i[cur_seq_q];

   // A full FIFO holds the result in PUSH, stalling the sequence
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_q <= `ADCSEQ_S_IDLE;
         cur_seq_q <= 2'b00;
         step_q <= 3'h0;
         step_word_q <= `ADCSEQ_STEP_RST;
         res_q <= {`ADCSEQ_RES_W{1'b0}};
         conv_start_q <= 1'b0;
         conv_channel_q <= 3'h0;
         conv_diff_q <= 1'b0;
         conv_temp_q <= 1'b0;
      end
      else
      begin
         conv_start_q <= 1'b0;
         case (state_q)
            `ADCSEQ_S_IDLE:
            begin
               if (start)
               begin
                  cur_seq_q <= win_seq;
                  step_q <= 3'h0;
                  state_q <= `ADCSEQ_S_LOAD;
               end
            end
            `ADCSEQ_S_LOAD:
            begin
               step_word_q <= step_mem[cur_idx];
               conv_channel_q <= step_mem[cur_idx][2:0];
               conv_diff_q <= step_mem[cur_idx][`ADCSEQ_STEP_DIFF];
               conv_temp_q <= step_mem[cur_idx][`ADCSEQ_STEP_TEMP];
               conv_start_q <= 1'b1;
               state_q <= `ADCSEQ_S_WAIT;
            end
            `ADCSEQ_S_WAIT:
            begin
               if (conv_done_i)
               begin
                  res_q <= conv_data_i;
                  state_q <= `ADCSEQ_S_PUSH;
               end
            end
            `ADCSEQ_S_PUSH:
            begin
               if (push_done)
               begin
                  if (seq_end)
                     state_q <= `ADCSEQ_S_IDLE;
                  else
                  begin
                     step_q <= step_q + 3'h1;
                     state_q <= `ADCSEQ_S_LOAD;
                  end
               end
            end
            default:
               state_q <= `ADCSEQ_S_IDLE;
         endcase
      end
   end

   // ============================================================
   // Result read-out
   // Two cycles of latency buy a flop-driven data output
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         rd_pend_q <= 1'b0;
         rd_sel_q <= 2'b00;
         rd_data_q <= {`ADCSEQ_RES_W{1'b0}};
         rd_valid_q <= 1'b0;
      end
      else
      begin
         rd_pend_q <= |(fifo_pop & fifo_out_valid);
         rd_sel_q <= rd_seq_i;
         rd_valid_q <= rd_pend_q;
         if (rd_pend_q)
            rd_data_q <= fifo_dout[`ADCSEQ_RES_W*rd_sel_q +:
               `ADCSEQ_RES_W];
      end
   end

   // ============================================================
   // Outputs
   assign rd_data_o = rd_data_q;
   assign rd_valid_o = rd_valid_q;
   assign seq_overflow_o = ovf_q;
   assign seq_underflow_o = unf_q;
   assign irq_raw_o = irq_q;
   assign irq_masked_o = irq_q & irq_mask_i;
   assign conv_start_o = conv_start_q;
   assign conv_channel_o = conv_channel_q;
   assign conv_diff_o = conv_diff_q;
   assign conv_temp_o = conv_temp_q;
   assign busy_o = (state_q != `ADCSEQ_S_IDLE);
   assign active_seq_o = cur_seq_q;
endmodule // adcseq_top

// >>> adcseq_top_sva.sv
// Checker on the ports of the sequencer top.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/100ps
module adcseq_top_sva (
   input wire clk_i,
   input wire rst_i,
   input wire [3:0] seq_enable_i,
   input wire [15:0] seq_trigger_select_i,
   input wire [3:0] proc_trig_i,
   input wire rd_i,
   input wire [1:0] rd_seq_i,
   input wire rd_valid_o,
   input wire [19:0] seq_fifo_count_o,
   input wire [3:0] seq_ovf_clr_i,
   input wire [3:0] seq_unf_clr_i,
   input wire [3:0] seq_overflow_o,
   input wire [3:0] seq_underflow_o,
   input wire [3:0] irq_mask_i,
   input wire [3:0] irq_clr_i,
   input wire [3:0] irq_raw_o,
   input wire [3:0] irq_masked_o,
   input wire conv_start_o,
   input wire [2:0] conv_channel_o,
   input wire conv_diff_o,
   input wire conv_temp_o,
   input wire busy_o
);
   // ==============================================================
   // Helpers
   // Fill of the sequencer being read
   wire [4:0] rd_cnt = seq_fifo_count_o[rd_seq_i*5 +: 5];
   wire trig0 = proc_trig_i[0] && seq_enable_i[0] &&
      seq_trigger_select_i[3:0] == 4'h0;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // ==============================================================
   // Properties
   a_start_one_cycle: assert property (conv_start_o |=> !conv_start_o)
      else $error("start pulse too long");
   a_start_after_trig: assert property (
      trig0 && !busy_o |-> ##[1:4] conv_start_o)
      else $error("no start after trigger");
   a_step_cfg_hold: assert property (!conv_start_o |->
      $stable({conv_channel_o, conv_diff_o, conv_temp_o}))
      else $error("step settings moved");
   a_disabled_quiet: assert property (
      (seq_enable_i == 4'h0) [*4] |-> !conv_start_o)
      else $error("start while disabled");
   a_rd_answer: assert property (
      rd_i && rd_cnt != 5'h00 |-> ##2 rd_valid_o)
      else $error("read gave no data");
   a_unf_set: assert property (rd_i && rd_cnt == 5'h00 |=>
      seq_underflow_o[$past(rd_seq_i)])
      else $error("no underflow flag");
   a_ovf_set: assert property (
      trig0 && seq_fifo_count_o[4:0] != 5'h00 |=> seq_overflow_o[0])
      else $error("no overflow flag");
   // Skip the edge after reset, which clears flags
   a_ovf_sticky: assert property (!$past(rst_i) |->
      (($past(seq_overflow_o & ~seq_ovf_clr_i) & ~seq_overflow_o) == 4'h0))
      else $error("overflow dropped");
   a_unf_sticky: assert property (!$past(rst_i) |->
      (($past(seq_underflow_o & ~seq_unf_clr_i) & ~seq_underflow_o) == 4'h0))
      else $error("underflow dropped");
   a_irq_clear: assert property (irq_clr_i != 4'h0 && !busy_o |=>
      ((irq_raw_o & $past(irq_clr_i)) == 4'h0))
      else $error("irq survived clear");
   a_irq_masked: assert property (
      irq_masked_o == (irq_raw_o & irq_mask_i))
      else $error("masked irq wrong");
   c_underflow: cover property (rd_i && rd_cnt == 5'h00);
   c_overflow: cover property (seq_overflow_o[0]);
   c_irq_seen: cover property (irq_masked_o != 4'h0);
endmodule // adcseq_top_sva

bind adcseq_top adcseq_top_sva u_sva (.clk_i(clk_i), .rst_i(rst_i),
   .seq_enable_i(seq_enable_i), .seq_trigger_select_i(seq_trigger_select_i),
   .proc_trig_i(proc_trig_i), .rd_i(rd_i), .rd_seq_i(rd_seq_i),
   .rd_valid_o(rd_valid_o), .seq_fifo_count_o(seq_fifo_count_o),
   .seq_ovf_clr_i(seq_ovf_clr_i), .seq_unf_clr_i(seq_unf_clr_i),
   .seq_overflow_o(seq_overflow_o), .seq_underflow_o(seq_underflow_o),
   .irq_mask_i(irq_mask_i), .irq_clr_i(irq_clr_i), .irq_raw_o(irq_raw_o),
   .irq_masked_o(irq_masked_o), .conv_start_o(conv_start_o),
   .conv_channel_o(conv_channel_o), .conv_diff_o(conv_diff_o),
   .conv_temp_o(conv_temp_o), .busy_o(busy_o));

// >>> adcseq_conv_model.sv
// Converter core model: one done pulse per start pulse.
// Assumes starts never overlap; slow_i picks a long conversion.
`timescale 1ns/100ps
module adcseq_conv_model (
   input wire clk_i,
   input wire rst_i,
   input wire start_i,
   input wire [2:0] channel_i,
   input wire diff_i,
   input wire temp_i,
   input wire slow_i,
   output reg done_o,
   output reg [11:0] data_o
);
   reg [3:0] wait_q;
   reg busy_q;
   reg [6:0] tag_q;
   reg [4:0] cfg_q;
   // ==============================================================
   // Conversion
   // Low bits echo the step; toggling outside done shows late samples
   always @(posedge clk_i)
   begin
      done_o <= 1'b0;
      data_o <= ~data_o;
      if (rst_i)
      begin
         busy_q <= 1'b0;
         tag_q <= 7'h00;
         data_o <= 12'h000;
      end
      else if (busy_q && wait_q == 4'h0)
      begin
         busy_q <= 1'b0;
         done_o <= 1'b1;
         data_o <= {tag_q, cfg_q};
         tag_q <= tag_q + 7'h01;
      end
      else if (busy_q)
         wait_q <= wait_q - 4'h1;
      else if (start_i)
      begin
         busy_q <= 1'b1;
         cfg_q <= {temp_i, diff_i, channel_i};
         wait_q <= slow_i ? 4'h9 : 4'h0;
      end
   end
endmodule // adcseq_conv_model

// >>> adc_sample_sequencer_test.sv
// Self-checking bench for the sequencer sampling control.
// Assumes the converter model; stimulus moves at the falling edge.
`timescale 1ns/100ps
module adc_sample_sequencer_test;
   reg clk_i = 1'b0;
   reg rst_i = 1'b1;
   reg [3:0] en = 4'h0, ptrig = 4'h0, oclr = 4'h0, uclr = 4'h0;
   reg [3:0] mask = 4'h0, iclr = 4'h0;
   reg [15:0] tsel = 16'h0000;
   reg [7:0] prio = 8'hE4, hw = 8'h00;
   reg we = 1'b0, rd = 1'b0, slow = 1'b0;
   reg [1:0] wseq = 2'h0, rseq = 2'h0, w2, last_act;
   reg [2:0] widx = 3'h0;
   reg [6:0] wword = 7'h00;
   wire [11:0] rdata, cdata;
   wire [19:0] cnt;
   wire [3:0] ovf, unf, iraw, imsk;
   wire [2:0] ch;
   wire [1:0] act;
   wire rvalid, start, diff, temp, done, busy;
   integer mismatches = 0;
   integer checks = 0;
   integer cyc = 0, nord = 0, g, i, k, p;
   integer nst [0:3];
   reg [6:0] steps [0:3][0:7];
   reg [1:0] order [0:7];

   always #25 clk_i = ~clk_i;

   adcseq_top dut (.clk_i(clk_i), .rst_i(rst_i), .seq_enable_i(en),
      .seq_trigger_select_i(tsel), .seq_priority_i(prio), .proc_trig_i(ptrig),
      .trig_comparator_first_i(hw[0]), .trig_comparator_second_i(hw[1]),
      .trig_comparator_third_i(hw[2]), .trig_external_i(hw[3]),
      .trig_timer_i(hw[4]), .trig_pwm_gen_first_i(hw[5]),
      .trig_pwm_gen_second_i(hw[6]), .trig_pwm_gen_third_i(hw[7]),
      .cfg_we_i(we), .cfg_seq_i(wseq), .seq_step_index_i(widx),
      .cfg_step_i(wword), .rd_i(rd), .rd_seq_i(rseq), .rd_data_o(rdata),
      .rd_valid_o(rvalid), .seq_fifo_count_o(cnt), .seq_ovf_clr_i(oclr),
      .seq_unf_clr_i(uclr), .seq_overflow_o(ovf), .seq_underflow_o(unf),
      .irq_mask_i(mask), .irq_clr_i(iclr), .irq_raw_o(iraw),
      .irq_masked_o(imsk), .conv_start_o(start), .conv_channel_o(ch),
      .conv_diff_o(diff), .conv_temp_o(temp), .conv_done_i(done),
      .conv_data_i(cdata), .busy_o(busy), .active_seq_o(act));

   adcseq_conv_model u_conv (.clk_i(clk_i), .rst_i(rst_i), .start_i(start),
      .channel_i(ch), .diff_i(diff), .temp_i(temp), .slow_i(slow),
      .done_o(done), .data_o(cdata));

   // ==============================================================
   // Run order log and hang guard
   always @(posedge clk_i)
   begin
      cyc = cyc + 1;
      if (start && (nord == 0 || act != last_act) && nord < 8)
      begin
         order[nord] = act;
         nord = nord + 1;
         last_act = act;
      end
      if (cyc == 20000)
      begin
         mismatches = mismatches + 1;
         close_out;
      end
   end

   // ==============================================================
   // Tasks and expectations
   function [11:0] exp_res(input [6:0] w);
      exp_res = {7'h00, w[4:0]};
   endfunction

   task chk(input [8*12:1] name, input [11:0] exp, input [11:0] got);
   begin
      checks = checks + 1;
      if (got !== exp)
      begin
         mismatches = mismatches + 1;
         $display("Error %0s expected %0h seen %0h", name, exp, got);
      end
   end
   endtask

   task tick;
      @(negedge clk_i);
   endtask

   // Waits for four idle cycles
   task settle;
   begin
      k = 0;
      p = 0;
      while (k < 4 && p < 600)
      begin
         tick;
         p = p + 1;
         k = busy ? 0 : k + 1;
      end
      if (p >= 600)
         mismatches = mismatches + 1;
   end
   endtask

   task trig(input [1:0] s);
   begin
      ptrig[s] = 1'b1;
      tick;
      ptrig[s] = 1'b0;
   end
   endtask

   // Random steps; differential only on pairs, never with temperature
   task load_steps(input [1:0] s);
   integer j;
   reg [6:0] w;
   begin
      en[s] = 1'b0;
      nst[s] = 1 + $urandom % (s == 0 ? 8 : (s == 3 ? 1 : 4));
      we = 1'b1;
      wseq = s;
      for (j = 0; j < nst[s]; j = j + 1)
      begin
         w = $urandom;
         w[3] = w[4] ? 1'b0 : w[3];
         w[2] = w[3] ? 1'b0 : w[2];
         w[6:5] = (j == nst[s] - 1) ? 2'h3 : {w[6], 1'b0};
         steps[s][j] = w;
         widx = j[2:0];
         wword = w;
         tick;
      end
      we = 1'b0;
   end
   endtask

   // Reads n words, then extra empty reads
   task drain(input [1:0] s, input integer n, input integer extra);
   integer j;
   begin
      for (j = 0; j < n + extra; j = j + 1)
      begin
         rseq = s;
         rd = 1'b1;
         tick;
         rd = 1'b0;
         tick;
         chk("valid", j < n, {11'h000, rvalid});
         if (j < n)
            chk("data", exp_res(steps[s][j % nst[s]]),
               {7'h00, rdata[4:0]});
      end
   end
   endtask

   task close_out;
   begin
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   end
   endtask

   // ==============================================================
   // Main sequence
   initial
   begin
      k = $urandom(42847);
      repeat (16) tick;
      rst_i = 1'b0;
      tick;
      for (g = 0; g < 4; g = g + 1)
      begin
         load_steps(g);
         tsel[4*g +: 4] = 4'h0;
         en[g] = 1'b1;
         mask = $urandom;
         slow = $urandom;
         trig(g);
         settle;
         chk("count", nst[g], cnt[5*g +: 5]);
         chk("irq raw", 12'h001, iraw[g]);
         chk("irq masked", mask[g], imsk[g]);
         iclr[g] = 1'b1;
         tick;
         iclr[g] = 1'b0;
         chk("irq clear", 12'h000, iraw[g]);
         trig(g);
         settle;
         chk("overflow", 12'h001, ovf[g]);
         chk("count", 2 * nst[g], cnt[5*g +: 5]);
         oclr[g] = 1'b1;
         tick;
         oclr[g] = 1'b0;
         chk("ovf clear", 12'h000, ovf[g]);
         drain(g, 2 * nst[g], 2);
         chk("underflow", 12'h001, unf[g]);
         uclr[g] = 1'b1;
         tick;
         uclr[g] = 1'b0;
         chk("unf clear", 12'h000, unf[g]);
         $display("test sequencer %0d done", g);
      end
      // Shuffled distinct priorities, all four pending at once
      for (i = 0; i < 4; i = i + 1)
      begin
         k = $urandom % 4;
         w2 = prio[2*i +: 2];
         prio[2*i +: 2] = prio[2*k +: 2];
         prio[2*k +: 2] = w2;
      end
      tsel = 16'h0000;
      en = 4'hF;
      nord = 0;
      ptrig = 4'hF;
      tick;
      ptrig = 4'h0;
      settle;
      for (i = 0; i < 4; i = i + 1)
         for (g = 0; g < 4; g = g + 1)
            if (prio[2*g +: 2] == i)
               chk("run order", g, order[i]);
      for (g = 0; g < 4; g = g + 1)
         drain(g, nst[g], 0);
      $display("test priority done");
      // Each hardware source held two cycles gives one run
      for (i = 1; i < 9; i = i + 1)
      begin
         en = 4'h8;
         tsel[15:12] = i[3:0];
         hw[i-1] = 1'b1;
         repeat (2) tick;
         hw[i-1] = 1'b0;
         settle;
         chk("hw trigger", 12'h001, cnt[19:15]);
         drain(3, 1, 0);
      end
      $display("test sources done");
      // Always trigger runs until disabled
      slow = 1'b0;
      tsel[15:12] = 4'hF;
      repeat (30) tick;
      en = 4'h0;
      settle;
      chk("always runs", 12'h001, cnt[19:15] > 5'h01);
      drain(3, cnt[19:15], 0);
      oclr = 4'hF;
      tick;
      oclr = 4'h0;
      // A trigger while disabled is dropped, not kept pending
      tsel[15:12] = 4'h0;
      trig(3);
      en[3] = 1'b1;
      repeat (12) tick;
      chk("disabled", 12'h000, {cnt[19:15], busy});
      $display("test always and disable done");
      close_out;
   end
endmodule // adc_sample_sequencer_test
